// file: verif/gp_timer_tb.sv
// self-checking bench for the general timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    n_tests++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("wrong value at %0t: %0h not %0h", $time, a, b); \
    end \
end
module gp_timer_tb import gp_timer_pkg::*;;
    logic clock, rst_b, count_gate_pin, reload_trigger_pin, timer_irq;
    timer_cfg_t cfg, cfg_rb;
    irq_cfg_t irq_cfg;
    irq_flags_t flag_clear, flags;
    logic [15:0] reload_value, count, c0;
    int failures = 0, n_tests = 0, cycles = 0, n;
    int ratio[8] = '{6, 24, 12, 48, 24, 96, 48, 192};
    gp_timer dut (.clock(clock), .rst_b(rst_b), .cfg(cfg), .irq_cfg(irq_cfg),
        .reload_value(reload_value), .count_gate_pin(count_gate_pin),
        .reload_trigger_pin(reload_trigger_pin), .flag_clear(flag_clear),
        .cfg_readback(cfg_rb), .count(count), .flags(flags), .timer_irq(timer_irq));
    pin_model pins (.clock(clock), .count_gate_pin(count_gate_pin),
        .reload_trigger_pin(reload_trigger_pin));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic next_change(output int k);
        c0 = count;
        k = 0;
        while (count === c0 && k < 1000) begin
            step(1);
            k++;
        end
    endtask
    task automatic wait_ovf();
        n = 0;
        while (flags.gp_timer_overflow_flag !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge clock) cfg <= 8'h0c;
        reload_value <= v;
        pins.fall_reload();
        @(posedge clock) flag_clear <= 2'h3;
        @(posedge clock) flag_clear <= 2'h0;
        step(1);
    endtask
    task automatic test_rate();
        for (int i = 0; i < 16; i++) begin
            @(posedge clock) cfg <= {i[3], i[0], i[2], i[1], 4'h1};
            next_change(n);
            next_change(n);
            next_change(n);
            `CHK(n, ratio[i[2:0]] << i[3])
            `CHK(count, c0 + 16'h0001)
            `CHK(cfg_rb, cfg)
        end
        $display("rate test done");
    endtask
    task automatic test_reload();
        load(16'hfff0);
        `CHK(count, 16'hfff0)
        `CHK(flags, 2'h0)
        @(posedge clock) irq_cfg <= 2'h3;
        reload_value <= 16'h1234;
        pins.fall_reload();
        step(60);
        `CHK(count, 16'h1234)
        `CHK(flags, 2'h1)
        `CHK(timer_irq, 1'b1)
        load(16'hfff0);
        @(posedge clock) cfg <= 8'h09;
        reload_value <= 16'h1234;
        wait_ovf();
        `CHK(count, 16'h1234)
        `CHK(flags, 2'h2)
        `CHK(timer_irq, 1'b1)
        @(posedge clock) irq_cfg <= 2'h1;
        step(1);
        `CHK(timer_irq, 1'b0)
        load(16'hfff0);
        @(posedge clock) cfg <= 8'h05;
        wait_ovf();
        `CHK(count, 16'h0000)
        @(posedge clock) cfg <= 8'h04;
        c0 = count;
        pins.fall_reload();
        `CHK(count, c0)
        $display("reload test done");
    endtask
    task automatic test_pin_modes();
        load(16'h0100);
        @(posedge clock) cfg <= 8'h02;
        repeat (3) pins.fall_count();
        `CHK(count, 16'h0103)
        @(posedge clock) cfg <= 8'h03;
        pins.set_gate(1'b0);
        step(30);
        c0 = count;
        step(60);
        `CHK(count, c0)
        pins.set_gate(1'b1);
        next_change(n);
        next_change(n);
        `CHK(n, 6)
        $display("pin mode test done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        cfg = 8'h00;
        irq_cfg = 2'h0;
        reload_value = 16'h0000;
        flag_clear = 2'h0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        step(20);
        `CHK({count, flags, timer_irq}, 19'h0_0000)
        test_rate();
        test_reload();
        test_pin_modes();
        end_of_test();
    end
endmodule
`default_nettype wire

// file: verif/pin_model.sv
// pin-side model driving the count/gate and reload trigger pins
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic clock,
    output logic count_gate_pin,
    output logic reload_trigger_pin
);
    initial begin
        count_gate_pin = 1'b1;
        reload_trigger_pin = 1'b1;
    end
    task automatic fall_count();
        @(posedge clock) count_gate_pin <= 1'b0;
        repeat (12) @(posedge clock);
        count_gate_pin <= 1'b1;
        repeat (12) @(posedge clock);
    endtask
    task automatic fall_reload();
        @(posedge clock) reload_trigger_pin <= 1'b0;
        repeat (12) @(posedge clock);
        reload_trigger_pin <= 1'b1;
        repeat (12) @(posedge clock);
    endtask
    task automatic set_gate(input logic v);
        @(posedge clock) count_gate_pin <= v;
    endtask
endmodule
`default_nettype wire

// file: verilog/gp_timer.sv
// 16-bit general timer with reload, event counter and gated modes
`timescale 1ns/1ps
`default_nettype none
module gp_timer
    import gp_timer_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire timer_cfg_t cfg,
    input wire irq_cfg_t irq_cfg,
    input wire logic [15:0] reload_value,
    input wire logic count_gate_pin,
    input wire logic reload_trigger_pin,
    input wire irq_flags_t flag_clear,
    output timer_cfg_t cfg_readback,
    output logic [15:0] count,
    output irq_flags_t flags,
    output logic timer_irq
);
    logic [2:0] mc_cnt_r;
    logic mc_tick;
    logic [5:0] presc_r;
    logic [5:0] presc_mask;
    logic presc_tick;
    logic gate_s1_r, gate_s2_r, gate_smp_r;
    logic trig_s1_r, trig_s2_r, trig_smp_r;
    logic count_edge_r, reload_edge_r;
    logic [1:0] src;
    logic inc;
    logic ovf;
    logic reload_ovf, reload_ext;
    logic [15:0] count_r;
    irq_flags_t flags_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mc_cnt_r <= mc_zero;
        end else if (mc_cnt_r == mc_last) begin
            mc_cnt_r <= mc_zero;
        end else begin
            mc_cnt_r <= mc_cnt_r + 3'h1;
        end
    end
    assign mc_tick = (mc_cnt_r == mc_last);

    // prescale ratio as power-of-two mask over machine cycles
    always_comb begin
        case ({cfg.prescale_sel_hi, cfg.prescale_sel_lo, cfg.prescale_extra_bit})
            3'h0: presc_mask = presc_div1;
            3'h1: presc_mask = presc_div4;
            3'h2: presc_mask = presc_div2;
            3'h3: presc_mask = presc_div8;
            3'h4: presc_mask = presc_div4;
            3'h5: presc_mask = presc_div16;
            3'h6: presc_mask = presc_div8;
            default: presc_mask = presc_div32;
        endcase
        if (cfg.prescale_range_bit) begin
            presc_mask = {presc_mask[4:0], 1'b1};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            presc_r <= presc_zero;
        end else if (mc_tick) begin
            presc_r <= presc_tick ? presc_zero : presc_r + 6'h01;
        end
    end
    assign presc_tick = mc_tick && ((presc_r & presc_mask) == presc_mask);

    // pin synchronisers then machine cycle samples
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_s1_r <= 1'b0;
            gate_s2_r <= 1'b0;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
        end else begin
            gate_s1_r <= count_gate_pin;
            gate_s2_r <= gate_s1_r;
            trig_s1_r <= reload_trigger_pin;
            trig_s2_r <= trig_s1_r;
        end
    end

    // sample once per machine cycle, edge acts next machine cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_smp_r <= 1'b0;
            trig_smp_r <= 1'b0;
            count_edge_r <= 1'b0;
            reload_edge_r <= 1'b0;
        end else if (mc_tick) begin
            gate_smp_r <= gate_s2_r;
            trig_smp_r <= trig_s2_r;
            count_edge_r <= gate_smp_r && !gate_s2_r;
            reload_edge_r <= trig_smp_r && !trig_s2_r;
        end
    end

    assign src = {cfg.input_sel_hi, cfg.input_sel_lo};
    always_comb begin
        case (src)
            src_timer: inc = presc_tick;
            src_count: inc = mc_tick && count_edge_r;
            src_gated: inc = presc_tick && gate_smp_r;
            default: inc = 1'b0;
        endcase
    end

    assign ovf = inc && (count_r == count_ones);
    assign reload_ovf = ovf && cfg.reload_mode_hi && !cfg.reload_mode_lo;
    assign reload_ext = mc_tick && reload_edge_r && cfg.reload_mode_hi && cfg.reload_mode_lo;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= count_zero;
        end else if (reload_ovf || reload_ext) begin
            count_r <= reload_value;
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= '0;
        end else begin
            flags_r.gp_timer_overflow_flag <= ovf
                || (flags_r.gp_timer_overflow_flag && !flag_clear.gp_timer_overflow_flag);
            flags_r.ext_reload_flag <= (reload_ext && irq_cfg.ext_reload_irq_enable)
                || (flags_r.ext_reload_flag && !flag_clear.ext_reload_flag);
        end
    end

    // shared interrupt request gated by enable
    assign timer_irq = irq_cfg.gp_timer_irq_enable
        && (flags_r.gp_timer_overflow_flag || flags_r.ext_reload_flag);
    assign cfg_readback = cfg;
    assign count = count_r;
    assign flags = flags_r;

    // assertions
    sequence wrap_s;
        inc && count_r == count_ones;
    endsequence

    sequence trig_fall_s;
        mc_tick && reload_edge_r;
    endsequence

    sequence pin_count_s;
        src == src_count && inc;
    endsequence

    // count moves by one or reload
    count_move_a: assert property (@(posedge clock) disable iff (!rst_b)
        !$stable(count_r) |-> count_r == $past(count_r) + 16'h0001
        || count_r == $past(reload_value)) else $error("count jumped");
    overflow_sets_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrap_s |=> flags_r.gp_timer_overflow_flag) else $error("overflow flag not set");
    ovf_reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrap_s ##0 (cfg.reload_mode_hi && !cfg.reload_mode_lo) |=> count_r == $past(reload_value))
        else $error("overflow reload missing");
    no_reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrap_s ##0 !cfg.reload_mode_hi |=> count_r == count_zero)
        else $error("reload while off");
    ext_reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        trig_fall_s ##0 (cfg.reload_mode_hi && cfg.reload_mode_lo)
        |=> count_r == $past(reload_value)) else $error("edge reload missing");
    stop_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        src == src_stop && !reload_ext |=> $stable(count_r)) else $error("stopped timer moved");
    mc_period_a: assert property (@(posedge clock) disable iff (!rst_b)
        mc_tick |=> !mc_tick [*5] ##1 mc_tick) else $error("machine cycle not six clocks");
    irq_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        !irq_cfg.gp_timer_irq_enable |-> !timer_irq) else $error("irq while disabled");
    ext_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
        reload_ext && !irq_cfg.ext_reload_irq_enable && !flags_r.ext_reload_flag
        |=> !flags_r.ext_reload_flag) else $error("ext flag set while disabled");
    ext_flag_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        reload_ext && irq_cfg.ext_reload_irq_enable |=> flags_r.ext_reload_flag)
        else $error("ext flag not set");
    step_one_a: assert property (@(posedge clock) disable iff (!rst_b)
        inc && !ovf && !reload_ext |=> count_r == $past(count_r) + 16'h0001)
        else $error("count step not one");
    gate_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        src == src_gated && !gate_smp_r && !reload_ext |=> $stable(count_r))
        else $error("gated timer moved while closed");
    count_rate_a: assert property (@(posedge clock) disable iff (!rst_b)
        pin_count_s |=> !(src == src_count && inc) [*8] ##1 !(src == src_count && inc) [*3])
        else $error("counter too fast");
endmodule
`default_nettype wire

// file: verilog/gp_timer_pkg.sv
// shared constants and types for the general timer
package gp_timer_pkg;
    // oscillator cycles per machine cycle
    localparam int unsigned mc_div = 6;
    localparam logic [2:0] mc_last = 3'h5;
    localparam logic [15:0] count_zero = 16'h0000;
    localparam logic [15:0] count_ones = 16'hffff;
    localparam logic [5:0] presc_zero = 6'h00;
    localparam logic [2:0] mc_zero = 3'h0;
    // prescale masks: machine cycles per tick minus one
    localparam logic [5:0] presc_div1 = 6'h00;
    localparam logic [5:0] presc_div2 = 6'h01;
    localparam logic [5:0] presc_div4 = 6'h03;
    localparam logic [5:0] presc_div8 = 6'h07;
    localparam logic [5:0] presc_div16 = 6'h0f;
    localparam logic [5:0] presc_div32 = 6'h1f;
    localparam logic [1:0] src_stop = 2'h0;
    localparam logic [1:0] src_timer = 2'h1;
    localparam logic [1:0] src_count = 2'h2;
    localparam logic [1:0] src_gated = 2'h3;

    typedef struct packed {
        logic prescale_range_bit;
        logic prescale_extra_bit;
        logic prescale_sel_hi;
        logic prescale_sel_lo;
        logic reload_mode_hi;
        logic reload_mode_lo;
        logic input_sel_hi;
        logic input_sel_lo;
    } timer_cfg_t;

    typedef struct packed {
        logic gp_timer_irq_enable;
        logic ext_reload_irq_enable;
    } irq_cfg_t;

    typedef struct packed {
        logic gp_timer_overflow_flag;
        logic ext_reload_flag;
    } irq_flags_t;
endpackage
